// >>> design/smm_pkg.sv
package smm_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_REF_ID = 8'h04;
   localparam logic [7:0] OFS_THRESH = 8'h08;
   localparam logic [7:0] OFS_TIMEOUT = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_LAST_ID = 8'h1C;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_MISMATCH = 0;
   localparam int CTRL_EN_MISSING = 1;
   localparam int CTRL_LINE_625 = 2;
   localparam int CTRL_FACTORY = 3;
   localparam int EV_MISMATCH = 0;
   localparam int EV_MISSING = 1;
   localparam int EV_ID_RX = 2;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0] CTRL_RST = 3'h3;
   localparam logic [15:0] REF_ID_RST = 16'h0000;
   localparam logic [15:0] THRESH_RST = 16'h0001;
   localparam logic [15:0] TIMEOUT_RST = 16'h0258;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage

// >>> design/smm_tick.sv
`timescale 1ns/1ns
module smm_tick #(
   parameter int CYCLES = smm_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   output logic tick
);
   initial begin
      if (CYCLES < 2) $error("smm_tick: CYCLES too small");
   end
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } smm_tick_st_t;
   smm_tick_st_t s_r;
   smm_tick_st_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (restart) begin
         s_nxt.cnt = 32'h0;
      end else if (s_r.cnt == 32'(CYCLES - 1)) begin
         s_nxt.cnt = 32'h0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 32'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign tick = s_r.tick;
endmodule

// >>> design/smm_cnt.sv
`timescale 1ns/1ns
module smm_cnt #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic inc,
   input wire logic [W-1:0] limit,
   output logic reached
);
   initial begin
      if (W < 2 || W > 32) $error("smm_cnt: W out of range");
   end
   typedef struct packed {
      logic [W-1:0] cnt;
   } smm_cnt_st_t;
   smm_cnt_st_t s_r;
   smm_cnt_st_t s_nxt;
   always_comb begin
      s_nxt = s_r;
      if (clr) begin
         s_nxt.cnt = '0;
      end else if (inc && s_r.cnt != '1) begin
         s_nxt.cnt = s_r.cnt + W'(1);
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign reached = (limit != '0) && (s_r.cnt >= limit);
endmodule

// >>> design/smm_monitor.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
// Function
// - A 16-bit reference id is held and each received id is compared with it.
// - The mismatch alarm rises only after the programmed number of consecutive mismatches.
// - The missing alarm rises when no id arrives within the programmed count of 100 ms ticks.
// - alarm_out_active_high is high while an enabled alarm condition holds, else low.
// - alarm_out_active_low is the exact inverse of alarm_out_active_high.
// - Each alarm has its own enable; a disabled alarm does not affect card status.
// - A factory-default request reloads every setting with its shipped value.
// - A setting selects 525-line or 625-line display operation.
module smm_monitor #(
   parameter int TICK_CYCLES = smm_pkg::TICK_CYCLES,
   parameter int CNT_W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic id_valid,
   input wire logic [15:0] id_data,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic alarm_out_active_high,
   output logic alarm_out_active_low,
   output logic card_status_ok,
   output logic display_line_standard,
   output logic irq
);
   initial begin
      if (CNT_W != 16) $error("smm_monitor: CNT_W must be 16");
      if (TICK_CYCLES < 2) $error("smm_monitor: TICK_CYCLES too small");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] ctrl;
      logic [15:0] ref_id;
      logic [15:0] thresh;
      logic [15:0] timeout;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [15:0] last_id;
      logic mis_alarm;
      logic miss_alarm;
      logic [31:0] prdata;
   } smm_st_t;
   smm_st_t s_r;
   smm_st_t s_nxt;

   logic mis_reached;
   logic miss_reached;
   logic tick;
   logic wr;
   logic rd;
   logic mismatch;
   logic factory;
   logic alarm;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign mismatch = id_valid && (id_data != s_r.ref_id);
   assign factory = wr && hit(paddr, smm_pkg::OFS_CTRL) && pwdata[smm_pkg::CTRL_FACTORY];

   // ------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------
   smm_cnt #(.W(CNT_W)) u_mis (
      .clk(clk),
      .rst_n(rst_n),
      .clr(id_valid && !mismatch),
      .inc(mismatch),
      .limit(s_r.thresh),
      .reached(mis_reached)
   );

   smm_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .rst_n(rst_n),
      .restart(id_valid),
      .tick(tick)
   );

   smm_cnt #(.W(CNT_W)) u_miss (
      .clk(clk),
      .rst_n(rst_n),
      .clr(id_valid),
      .inc(tick),
      .limit(s_r.timeout),
      .reached(miss_reached)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [2:0] ev;
      ev = 3'h0;
      s_nxt = s_r;
      s_nxt.mis_alarm = mis_reached;
      s_nxt.miss_alarm = miss_reached;
      ev[smm_pkg::EV_MISMATCH] = mis_reached && !s_r.mis_alarm;
      ev[smm_pkg::EV_MISSING] = miss_reached && !s_r.miss_alarm;
      ev[smm_pkg::EV_ID_RX] = id_valid;
      if (id_valid) begin
         s_nxt.last_id = id_data;
      end
      if (rd) begin
         unique case (paddr)
            smm_pkg::OFS_CTRL: s_nxt.prdata = {29'h0, s_r.ctrl};
            smm_pkg::OFS_REF_ID: s_nxt.prdata = {16'h0, s_r.ref_id};
            smm_pkg::OFS_THRESH: s_nxt.prdata = {16'h0, s_r.thresh};
            smm_pkg::OFS_TIMEOUT: s_nxt.prdata = {16'h0, s_r.timeout};
            smm_pkg::OFS_STATUS: s_nxt.prdata = {29'h0, !alarm, s_r.miss_alarm,
               s_r.mis_alarm};
            smm_pkg::OFS_IRQ_STAT: s_nxt.prdata = {29'h0, s_r.irq_stat};
            smm_pkg::OFS_IRQ_MASK: s_nxt.prdata = {29'h0, s_r.irq_mask};
            smm_pkg::OFS_LAST_ID: s_nxt.prdata = {16'h0, s_r.last_id};
            default: s_nxt.prdata = 32'h0;
         endcase
      end
      if (wr) begin
         if (hit(paddr, smm_pkg::OFS_CTRL)) s_nxt.ctrl = pwdata[2:0];
         if (hit(paddr, smm_pkg::OFS_REF_ID)) s_nxt.ref_id = pwdata[15:0];
         if (hit(paddr, smm_pkg::OFS_THRESH)) s_nxt.thresh = pwdata[15:0];
         if (hit(paddr, smm_pkg::OFS_TIMEOUT)) s_nxt.timeout = pwdata[15:0];
         if (hit(paddr, smm_pkg::OFS_IRQ_MASK)) s_nxt.irq_mask = pwdata[2:0];
         if (hit(paddr, smm_pkg::OFS_IRQ_STAT)) s_nxt.irq_stat = s_r.irq_stat & ~pwdata[2:0];
      end
      if (factory) begin
         s_nxt.ctrl = smm_pkg::CTRL_RST;
         s_nxt.ref_id = smm_pkg::REF_ID_RST;
         s_nxt.thresh = smm_pkg::THRESH_RST;
         s_nxt.timeout = smm_pkg::TIMEOUT_RST;
         s_nxt.irq_mask = smm_pkg::IRQ_MASK_RST;
      end
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.ctrl <= smm_pkg::CTRL_RST;
         s_r.ref_id <= smm_pkg::REF_ID_RST;
         s_r.thresh <= smm_pkg::THRESH_RST;
         s_r.timeout <= smm_pkg::TIMEOUT_RST;
         s_r.irq_mask <= smm_pkg::IRQ_MASK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign alarm = (s_r.mis_alarm && s_r.ctrl[smm_pkg::CTRL_EN_MISMATCH]) ||
      (s_r.miss_alarm && s_r.ctrl[smm_pkg::CTRL_EN_MISSING]);
   assign alarm_out_active_high = alarm;
   assign alarm_out_active_low = !alarm;
   assign card_status_ok = !alarm;
   assign display_line_standard = s_r.ctrl[smm_pkg::CTRL_LINE_625];
   assign irq = |(s_r.irq_stat & s_r.irq_mask);
   assign prdata = s_r.prdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ------------------------------------------------------------
   // Checks: alarm outputs
   // ------------------------------------------------------------
   polarity_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      alarm_out_active_high != alarm_out_active_low)
      else $error("alarm outputs not complementary");

   high_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.mis_alarm && s_r.ctrl[smm_pkg::CTRL_EN_MISMATCH]) |-> alarm_out_active_high)
      else $error("active high alarm missing");

   miss_drives_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.miss_alarm && s_r.ctrl[smm_pkg::CTRL_EN_MISSING]) |-> alarm_out_active_high)
      else $error("missing alarm not driven");

   high_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!s_r.mis_alarm && !s_r.miss_alarm) |-> !alarm_out_active_high)
      else $error("alarm high without cause");

   low_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.miss_alarm && s_r.ctrl[smm_pkg::CTRL_EN_MISSING]) |-> !alarm_out_active_low)
      else $error("active low alarm missing");

   disabled_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.ctrl[1:0] == 2'h0) |-> (card_status_ok && !alarm_out_active_high))
      else $error("disabled alarms still active");

   mis_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!s_r.ctrl[smm_pkg::CTRL_EN_MISMATCH] && !s_r.miss_alarm) |-> card_status_ok)
      else $error("disabled mismatch alarm reached card status");

   miss_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!s_r.ctrl[smm_pkg::CTRL_EN_MISSING] && !s_r.mis_alarm) |-> card_status_ok)
      else $error("disabled missing alarm reached card status");

   // ------------------------------------------------------------
   // Checks: link counters
   // ------------------------------------------------------------
   mismatch_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mismatch && s_r.thresh == 16'h0001 && !factory && !wr) |=> ##1 s_r.mis_alarm)
      else $error("single mismatch did not alarm");

   match_clears_a: assert property (@(posedge clk) disable iff (!rst_n)
      (id_valid && !mismatch) |=> ##1 !s_r.mis_alarm)
      else $error("match did not clear mismatch alarm");

   id_clears_miss_a: assert property (@(posedge clk) disable iff (!rst_n)
      id_valid |=> ##1 !s_r.miss_alarm)
      else $error("id did not clear missing alarm");

   ref_compare_a: assert property (@(posedge clk) disable iff (!rst_n)
      (id_valid && id_data == s_r.ref_id) |-> !mismatch)
      else $error("matching id flagged as mismatch");

   mismatch_seen_a: assert property (@(posedge clk) disable iff (!rst_n)
      (id_valid && id_data != s_r.ref_id) |-> mismatch)
      else $error("differing id not flagged");

   idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      !id_valid |-> !mismatch)
      else $error("mismatch without received id");

   thresh_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.thresh == 16'h0000) |=> !s_r.mis_alarm)
      else $error("mismatch alarm while threshold off");

   timeout_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.timeout == 16'h0000) |=> !s_r.miss_alarm)
      else $error("missing alarm while timeout off");

   mis_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mis_reached && !id_valid && !wr) |=> mis_reached)
      else $error("mismatch count fell without an id");

   miss_holds_a: assert property (@(posedge clk) disable iff (!rst_n)
      (miss_reached && !id_valid && !wr) |=> miss_reached)
      else $error("timeout count fell without an id");

   mis_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> s_r.mis_alarm == $past(mis_reached))
      else $error("mismatch alarm not registered");

   miss_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> s_r.miss_alarm == $past(miss_reached))
      else $error("missing alarm not registered");

   match_restarts_a: assert property (@(posedge clk) disable iff (!rst_n)
      (id_valid && !mismatch) |=> !mis_reached)
      else $error("match did not restart mismatch count");

   id_restarts_a: assert property (@(posedge clk) disable iff (!rst_n)
      id_valid |=> !miss_reached)
      else $error("id did not restart timeout count");

   // ------------------------------------------------------------
   // Checks: settings
   // ------------------------------------------------------------
   factory_load_a: assert property (@(posedge clk) disable iff (!rst_n)
      factory |=> (s_r.thresh == smm_pkg::THRESH_RST && s_r.timeout == smm_pkg::TIMEOUT_RST
      && s_r.ref_id == smm_pkg::REF_ID_RST))
      else $error("factory defaults not restored");

   factory_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
      factory |=> (s_r.ctrl == smm_pkg::CTRL_RST && s_r.irq_mask == smm_pkg::IRQ_MASK_RST))
      else $error("factory control defaults not restored");

   line_factory_a: assert property (@(posedge clk) disable iff (!rst_n)
      factory |=> display_line_standard == smm_pkg::CTRL_RST[smm_pkg::CTRL_LINE_625])
      else $error("factory line standard not restored");

   line_std_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && paddr == smm_pkg::OFS_CTRL && !pwdata[smm_pkg::CTRL_FACTORY])
      |=> display_line_standard == $past(pwdata[smm_pkg::CTRL_LINE_625]))
      else $error("line standard not taken");

   line_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr && paddr == smm_pkg::OFS_CTRL) |=> $stable(display_line_standard))
      else $error("line standard changed without a write");

   ref_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && paddr == smm_pkg::OFS_REF_ID) |=> s_r.ref_id == $past(pwdata[15:0]))
      else $error("reference id not taken");

   ref_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(wr && (paddr == smm_pkg::OFS_REF_ID || paddr == smm_pkg::OFS_CTRL))
      |=> $stable(s_r.ref_id))
      else $error("reference id changed without a write");

   thresh_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && paddr == smm_pkg::OFS_THRESH) |=> s_r.thresh == $past(pwdata[15:0]))
      else $error("threshold not taken");

   timeout_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && paddr == smm_pkg::OFS_TIMEOUT) |=> s_r.timeout == $past(pwdata[15:0]))
      else $error("timeout not taken");

   mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr && paddr == smm_pkg::OFS_IRQ_MASK) |=> s_r.irq_mask == $past(pwdata[2:0]))
      else $error("interrupt mask not taken");

   // ------------------------------------------------------------
   // Checks: events and reads
   // ------------------------------------------------------------
   id_event_a: assert property (@(posedge clk) disable iff (!rst_n)
      id_valid |=> s_r.irq_stat[smm_pkg::EV_ID_RX])
      else $error("id event not recorded");

   mis_event_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mis_reached && !s_r.mis_alarm) |=> s_r.irq_stat[smm_pkg::EV_MISMATCH])
      else $error("mismatch event not recorded");

   miss_event_a: assert property (@(posedge clk) disable iff (!rst_n)
      (miss_reached && !s_r.miss_alarm) |=> s_r.irq_stat[smm_pkg::EV_MISSING])
      else $error("missing event not recorded");

   stat_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_r.irq_stat[smm_pkg::EV_MISMATCH] && !(wr && paddr == smm_pkg::OFS_IRQ_STAT))
      |=> s_r.irq_stat[smm_pkg::EV_MISMATCH])
      else $error("event bit lost without a clear");

   last_id_a: assert property (@(posedge clk) disable iff (!rst_n)
      id_valid |=> s_r.last_id == $past(id_data))
      else $error("received id not captured");

   read_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && paddr == smm_pkg::OFS_REF_ID) |=> prdata == {16'h0000, $past(s_r.ref_id)})
      else $error("reference id read wrong");

   read_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && paddr == smm_pkg::OFS_CTRL) |=> prdata == {29'h0, $past(s_r.ctrl)})
      else $error("control read wrong");

   read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !rd |=> $stable(prdata))
      else $error("read data changed without a read");
endmodule

// >>> bench/smm_src.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Upstream stream source: one id per pulse, line inverted between ids
// ------------------------------------------------------------
module smm_src (
   input wire logic clk,
   output logic id_valid,
   output logic [15:0] id_data
);
   initial begin
      id_valid = 1'b0;
      id_data = 16'hFFFF;
   end
   task automatic send(input logic [15:0] id);
      @(posedge clk);
      id_valid <= 1'b1;
      id_data <= id;
      @(posedge clk);
      id_valid <= 1'b0;
      id_data <= ~id;
   endtask
endmodule

// >>> bench/smm_monitor_tb.sv
`timescale 1ns/1ns
module smm_monitor_tb;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic pready, pslverr, al_hi, al_lo, card_ok, line_std, irq, id_valid;
   logic [15:0] id_data;
   int error_cnt = 0, n_tests = 0;
   always #25 clk = ~clk;
   smm_src smm_src_i (.clk(clk), .id_valid(id_valid), .id_data(id_data));
   smm_monitor #(.TICK_CYCLES(10)) smm_monitor_i (.clk(clk), .rst_n(rst_n),
      .id_valid(id_valid), .id_data(id_data), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .alarm_out_active_high(al_hi), .alarm_out_active_low(al_lo),
      .card_status_ok(card_ok), .display_line_standard(line_std), .irq(irq));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd_v = prdata;
      chk(pslverr === 1'b0, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         chk(1'b0, "pready timeout");
         tally_and_finish();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_v === e, "read value");
   endtask
   task automatic al_stays(input logic e, input int n);
      logic ok;
      ok = 1'b1;
      repeat (n) begin
         @(negedge clk);
         if (al_hi !== e || al_lo !== ~e) ok = 1'b0;
      end
      chk(ok, "alarm moved early");
   endtask
   task automatic al_within(input logic e, input int n);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (al_hi !== e && k < n);
      chk(al_hi === e && al_lo === ~e, "alarm level");
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(al_hi === 1'b0 && al_lo === 1'b1 && card_ok === 1'b1, "reset alarms");
      rd(smm_pkg::OFS_CTRL, 32'h3);
      rd(smm_pkg::OFS_THRESH, 32'h1);
      rd(smm_pkg::OFS_TIMEOUT, 32'h258);
      rd(smm_pkg::OFS_IRQ_MASK, 32'h0);
      rd(8'h20, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_mismatch();
      apb(1'b1, smm_pkg::OFS_REF_ID, 32'h1234);
      apb(1'b1, smm_pkg::OFS_THRESH, 32'h3);
      apb(1'b1, smm_pkg::OFS_TIMEOUT, 32'h0);
      apb(1'b1, smm_pkg::OFS_IRQ_MASK, 32'h1);
      repeat (2) smm_src_i.send(16'h1111);
      smm_src_i.send(16'h1234);
      repeat (2) smm_src_i.send(16'h1111);
      al_stays(1'b0, 6);
      smm_src_i.send(16'h1111);
      al_within(1'b1, 4);
      chk(card_ok === 1'b0 && irq === 1'b1, "card or irq");
      apb(1'b1, smm_pkg::OFS_IRQ_STAT, 32'h7);
      @(negedge clk);
      chk(irq === 1'b0, "irq clear");
      smm_src_i.send(16'h1234);
      al_within(1'b0, 4);
      $display("mismatch test done");
   endtask
   task automatic t_enable();
      apb(1'b1, smm_pkg::OFS_THRESH, 32'h1);
      apb(1'b1, smm_pkg::OFS_CTRL, 32'h2);
      smm_src_i.send(16'h2222);
      al_stays(1'b0, 4);
      chk(card_ok === 1'b1, "card ok");
      rd(smm_pkg::OFS_LAST_ID, 32'h2222);
      apb(1'b0, smm_pkg::OFS_STATUS, 32'h0);
      chk(rd_v[0] === 1'b1, "raw alarm");
      smm_src_i.send(16'h1234);
      $display("enable test done");
   endtask
   task automatic t_timeout();
      apb(1'b1, smm_pkg::OFS_CTRL, 32'h3);
      apb(1'b1, smm_pkg::OFS_TIMEOUT, 32'h3);
      smm_src_i.send(16'h1234);
      al_stays(1'b0, 24);
      al_within(1'b1, 20);
      rd(smm_pkg::OFS_IRQ_STAT, 32'h7);
      smm_src_i.send(16'h1234);
      al_within(1'b0, 4);
      $display("timeout test done");
   endtask
   task automatic t_factory();
      apb(1'b1, smm_pkg::OFS_CTRL, 32'h7);
      @(negedge clk);
      chk(line_std === 1'b1, "625 line");
      apb(1'b1, smm_pkg::OFS_CTRL, 32'h8);
      @(negedge clk);
      chk(line_std === 1'b0, "525 line");
      rd(smm_pkg::OFS_REF_ID, 32'h0);
      rd(smm_pkg::OFS_THRESH, 32'h1);
      rd(smm_pkg::OFS_TIMEOUT, 32'h258);
      rd(smm_pkg::OFS_CTRL, 32'h3);
      $display("factory test done");
   endtask
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_reset();
      t_mismatch();
      t_enable();
      t_timeout();
      t_factory();
      tally_and_finish();
   end
endmodule
